// ===== hdl/fsp_pkg.sv
/*
 Shared constants of the flash status and protection block:
 register offsets, status bit positions, command codes, reset values.
 Assumes a byte-wide register port with a 4-bit offset.
*/
package fsp_pkg;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFFS_FLASH_CONFIG = 4'h3;
   localparam logic [ADDR_W-1:0] OFFS_PROTECTION   = 4'h4;
   localparam logic [ADDR_W-1:0] OFFS_FLASH_STATUS = 4'h5;

   // ------------------------------------------------------------
   // Status and configuration bit positions
   // ------------------------------------------------------------
   localparam int BIT_BUFFER_EMPTY  = 7;
   localparam int BIT_CMD_COMPLETE  = 6;
   localparam int BIT_PROT_VIOL     = 5;
   localparam int BIT_ACCESS_ERR    = 4;
   localparam int BIT_BLANK         = 2;
   localparam int BIT_FAIL          = 1;
   localparam int BIT_DONE          = 0;
   localparam int BIT_BE_IRQ_EN     = 7;
   localparam int BIT_CC_IRQ_EN     = 6;

   // ------------------------------------------------------------
   // Protection scenarios and command codes
   // ------------------------------------------------------------
   localparam int SCEN_W = 3;
   localparam logic [SCEN_W-1:0] SCEN_RESET = 3'h7;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
   localparam logic [7:0] CMD_WORD_PROGRAM = 8'h20;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
   localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_ADDR,
      SEQ_CMD
   } fsp_seq_type;

endpackage : fsp_pkg

// ===== hdl/fsp_status.sv
/*
 Status flags of the flash command controller and the guard on the
 protection scenario register.
 Assumes the command engine, address/data/command buffers and the
 array sit outside and talk through one-cycle pulses and levels, all
 on clk_i.
 Assumes engine_busy_i covers both the active and the buffered
 command, and buffer_free_i pulses once the buffered command has been
 taken, so that buffer-empty sets again.
 Assumes special_mode_i and stop_i come from logic on clk_i and need
 no synchroniser.
*/
// The plain strobed port was decided locally.
// Overview of operation
// - A disallowed protection scenario write is dropped; register unchanged.
// - Protection register reads back the scenario in force.
// - Allowed scenario moves follow the fixed from/to table.
// - Status register sits at offset 0x05.
// - Normal mode: empty, violation, error writable; complete, blank read-only; rest zero.
// - Special mode: fail is read/write, done is read-only.
// - Buffer-empty at bit 7; write 1 clears, write 0 no effect.
// - Writing 0 to buffer-empty mid-sequence aborts and sets access error.
// - Writing 0 to buffer-empty outside a sequence sets no error.
// - Buffer-empty with its enable raises an interrupt request.
// - Complete at bit 6; clear while buffer busy, set when all finish.
// - Complete stays clear when a buffered command is fetched at once.
// - Complete with its enable raises an interrupt request.
// - Violation at bit 5 set on protected program/erase; write 1 clears.
// - No launch while violation is set.
// - Access error at bit 4 on sequence fault, bad code, stop while busy.
// - Access error clears only on write 1 and blocks launch.
// - Blank at bit 2 set on verify pass, cleared on valid launch.
// - Special mode: fail at bit 1 set on verify fail, write 1 clears, blocks launch.
// - Special mode: done at bit 0 low while an operation is active.
`timescale 1ns/1ps

module fsp_status (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      reset_i,
   // Register port
   input  wire logic [fsp_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [fsp_pkg::DATA_W-1:0] wr_data_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [fsp_pkg::DATA_W-1:0] rd_data_o,
   // Mode and protection load from the array
   input  wire logic                      special_mode_i,
   input  wire logic                      prot_load_i,
   input  wire logic [fsp_pkg::SCEN_W-1:0] prot_init_i,
   output logic      [fsp_pkg::SCEN_W-1:0] protection_scenario_o,
   // Command write sequence events
   input  wire logic                      array_word_wr_i,
   input  wire logic                      cmd_wr_i,
   input  wire logic [7:0]                command_code_bits_i,
   input  wire logic                      stop_i,
   // Command engine
   output logic                           cmd_launch_o,
   input  wire logic                      buffer_free_i,
   input  wire logic                      engine_busy_i,
   input  wire logic                      op_active_i,
   input  wire logic                      prot_viol_i,
   input  wire logic                      verify_pass_i,
   input  wire logic                      verify_fail_i,
   // Interrupt requests
   output logic                           buffer_empty_irq_o,
   output logic                           cmd_complete_irq_o
);
   import fsp_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // The status map, the move table and the read mux are written for a
   // byte-wide port and eight scenarios; other sizes would drop bits.
   if (DATA_W != 8) begin : g_check_data_w
      $error("fsp_status: register port must be 8 bits wide");
   end
   if (SCEN_W != 3) begin : g_check_scen_w
      $error("fsp_status: protection scenario must be 3 bits wide");
   end
   if (ADDR_W < 3) begin : g_check_addr_w
      $error("fsp_status: register offsets do not fit the address");
   end
   if ((OFFS_FLASH_CONFIG == OFFS_PROTECTION) ||
       (OFFS_PROTECTION == OFFS_FLASH_STATUS) ||
       (OFFS_FLASH_CONFIG == OFFS_FLASH_STATUS)) begin : g_check_offs
      $error("fsp_status: register offsets overlap");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic move_ok(input logic [SCEN_W-1:0] from_s,
                                    input logic [SCEN_W-1:0] to_s);
      logic [7:0] allowed;
      allowed = 8'h00;
      case (from_s)
         3'h0: allowed = 8'h0f;
         3'h1: allowed = 8'h0a;
         3'h2: allowed = 8'h0c;
         3'h3: allowed = 8'h08;
         3'h4: allowed = 8'h18;
         3'h5: allowed = 8'h3c;
         3'h6: allowed = 8'h5a;
         3'h7: allowed = 8'hff;
         default: allowed = 8'h00;
      endcase
      return allowed[to_s];
   endfunction : move_ok

   function automatic logic code_ok(input logic [7:0] code);
      return (code == CMD_ERASE_VERIFY) || (code == CMD_WORD_PROGRAM) ||
             (code == CMD_SECTOR_ERASE) || (code == CMD_MASS_ERASE);
   endfunction : code_ok

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [SCEN_W-1:0] protection_config;
   logic              buffer_empty_irq_en;
   logic              cmd_complete_irq_en;
   logic              buffer_empty_flag;
   logic              cmd_complete_flag;
   logic              protect_violation_flag;
   logic              access_error_flag;
   logic              blank_flag;
   logic              fail_flag;
   fsp_seq_type       seq;
   fsp_seq_type       next_seq;

   logic wr_status;
   logic wr_prot;
   logic wr_config;
   logic w1c_be;
   logic w0_be;
   logic w1c_pv;
   logic w1c_ae;
   logic w1c_fail;
   logic launch_blocked;
   logic launch;
   logic seq_error;
   logic stop_error;

   // Write decode; offsets outside the map are simply ignored
   assign wr_status = wr_i && (addr_i == OFFS_FLASH_STATUS);
   assign wr_prot   = wr_i && (addr_i == OFFS_PROTECTION);
   assign wr_config = wr_i && (addr_i == OFFS_FLASH_CONFIG);

   // Each clear reads only its own bit of the written byte
   assign w1c_be   = wr_status && wr_data_i[BIT_BUFFER_EMPTY];
   assign w0_be    = wr_status && !wr_data_i[BIT_BUFFER_EMPTY];
   assign w1c_pv   = wr_status && wr_data_i[BIT_PROT_VIOL];
   assign w1c_ae   = wr_status && wr_data_i[BIT_ACCESS_ERR];
   assign w1c_fail = wr_status && wr_data_i[BIT_FAIL] && special_mode_i;

   // Fail blocks in either mode; it can only be set in special mode
   assign launch_blocked = protect_violation_flag
                        || access_error_flag
                        || fail_flag;

   // ------------------------------------------------------------
   // Command write sequence
   // ------------------------------------------------------------
   // Idle waits for the word write, the address stage for the command
   // code and the command stage for the launching write of one to
   // buffer-empty; a word, command or zero write out of turn aborts.
   always_comb begin
      next_seq  = seq;
      launch    = 1'b0;
      seq_error = 1'b0;
      case (seq)
         SEQ_IDLE: begin
            // A zero write to buffer-empty here is simply ignored
            if (cmd_wr_i) begin
               seq_error = 1'b1;
            end else if (array_word_wr_i && !launch_blocked) begin
               next_seq = SEQ_ADDR;
            end
         end
         SEQ_ADDR: begin
            if (cmd_wr_i) begin
               if (code_ok(command_code_bits_i)) begin
                  next_seq = SEQ_CMD;
               end else begin
                  seq_error = 1'b1;
                  next_seq  = SEQ_IDLE;
               end
            end else if (array_word_wr_i || w0_be) begin
               seq_error = 1'b1;
               next_seq  = SEQ_IDLE;
            end
         end
         SEQ_CMD: begin
            if (array_word_wr_i || cmd_wr_i || w0_be) begin
               seq_error = 1'b1;
               next_seq  = SEQ_IDLE;
            end else if (w1c_be) begin
               launch   = !launch_blocked;
               next_seq = SEQ_IDLE;
            end
         end
         default: begin
            next_seq = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         seq <= SEQ_IDLE;
      end else begin
         seq <= next_seq;
      end
   end

   // Registered so the engine sees a clean one-cycle pulse
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_launch_o <= 1'b0;
      end else begin
         cmd_launch_o <= launch;
      end
   end

   // ------------------------------------------------------------
   // Status flags; a hardware set wins over a same-cycle clear, except on complete, where the clear wins
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         buffer_empty_flag <= 1'b1;
      end else if (buffer_free_i) begin
         buffer_empty_flag <= 1'b1;
      end else if (w1c_be) begin
         buffer_empty_flag <= 1'b0;
      end
   end

   // Busy covers active and buffered commands, so a fetch straight
   // after a finish never opens a gap that would set the flag.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_complete_flag <= 1'b1;
      end else if (launch || !buffer_empty_flag) begin
         cmd_complete_flag <= 1'b0;
      end else if (!engine_busy_i) begin
         cmd_complete_flag <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         protect_violation_flag <= 1'b0;
      end else if (prot_viol_i) begin
         protect_violation_flag <= 1'b1;
      end else if (w1c_pv) begin
         protect_violation_flag <= 1'b0;
      end
   end

   // A stop only hurts while a command runs, that is while complete is low
   assign stop_error = stop_i && !cmd_complete_flag;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         access_error_flag <= 1'b0;
      end else if (seq_error || stop_error) begin
         access_error_flag <= 1'b1;
      end else if (w1c_ae) begin
         access_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         blank_flag <= 1'b0;
      end else if (verify_pass_i) begin
         blank_flag <= 1'b1;
      end else if (launch) begin
         blank_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fail_flag <= 1'b0;
      end else if (verify_fail_i && special_mode_i) begin
         fail_flag <= 1'b1;
      end else if (w1c_fail) begin
         fail_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Protection scenario and configuration
   // ------------------------------------------------------------
   // The array load is trusted; software may only tighten protection.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         protection_config <= SCEN_RESET;
      end else if (prot_load_i) begin
         protection_config <= prot_init_i;
      end else if (wr_prot &&
                   move_ok(protection_config, wr_data_i[SCEN_W-1:0])) begin
         protection_config <= wr_data_i[SCEN_W-1:0];
      end
   end

   // Interrupt enables share the configuration byte
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         buffer_empty_irq_en <= 1'b0;
         cmd_complete_irq_en <= 1'b0;
      end else if (wr_config) begin
         buffer_empty_irq_en <= wr_data_i[BIT_BE_IRQ_EN];
         cmd_complete_irq_en <= wr_data_i[BIT_CC_IRQ_EN];
      end
   end

   // Requests lag their flag by one cycle but never glitch
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         buffer_empty_irq_o <= 1'b0;
         cmd_complete_irq_o <= 1'b0;
         protection_scenario_o <= SCEN_RESET;
      end else begin
         buffer_empty_irq_o <= buffer_empty_flag && buffer_empty_irq_en;
         cmd_complete_irq_o <= cmd_complete_flag && cmd_complete_irq_en;
         protection_scenario_o <= protection_config;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   // Reads have no side effects, so polling never disturbs a sequence
   logic [DATA_W-1:0] status_view;

   always_comb begin
      status_view = '0;
      status_view[BIT_BUFFER_EMPTY] = buffer_empty_flag;
      status_view[BIT_CMD_COMPLETE] = cmd_complete_flag;
      status_view[BIT_PROT_VIOL]    = protect_violation_flag;
      status_view[BIT_ACCESS_ERR]   = access_error_flag;
      status_view[BIT_BLANK]        = blank_flag;
      if (special_mode_i) begin
         status_view[BIT_FAIL] = fail_flag;
         status_view[BIT_DONE] = !op_active_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_data_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            OFFS_FLASH_STATUS: rd_data_o <= status_view;
            OFFS_PROTECTION: begin
               rd_data_o <= {{(DATA_W-SCEN_W){1'b0}}, protection_config};
            end
            OFFS_FLASH_CONFIG: begin
               rd_data_o <= '0;
               rd_data_o[BIT_BE_IRQ_EN] <= buffer_empty_irq_en;
               rd_data_o[BIT_CC_IRQ_EN] <= cmd_complete_irq_en;
            end
            default: rd_data_o <= '0;
         endcase
      end else begin
         rd_data_o <= '0;
      end
   end

endmodule : fsp_status

// ===== sim/fsp_status_sva.sv
/* Port-level assertions for the flash status block.
   Assumes one clock, synchronous active-high reset, bound to fsp_status. */
`timescale 1ns/1ps
module fsp_status_sva (
   // Clock, reset and register port
   input wire logic                         clk_i,
   input wire logic                         reset_i,
   input wire logic [fsp_pkg::ADDR_W-1:0]   addr_i,
   input wire logic [fsp_pkg::DATA_W-1:0]   wr_data_i,
   input wire logic                         wr_i,
   input wire logic                         rd_i,
   input wire logic [fsp_pkg::DATA_W-1:0]   rd_data_o,
   // Mode, protection and engine side
   input wire logic                         special_mode_i,
   input wire logic                         prot_load_i,
   input wire logic [fsp_pkg::SCEN_W-1:0]   protection_scenario_o,
   input wire logic                         op_active_i,
   input wire logic                         cmd_launch_o,
   input wire logic                         buffer_empty_irq_o
);
   import fsp_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence status_rd;
      rd_i && addr_i == OFFS_FLASH_STATUS;
   endsequence
   sequence prot_touch;
      prot_load_i || (wr_i && addr_i == OFFS_PROTECTION);
   endsequence
   launch_pulse_a: assert property (cmd_launch_o |=> !cmd_launch_o)
      else $error("launch longer than one cycle");
   launch_cause_a: assert property (cmd_launch_o |->
      $past(wr_i && addr_i == OFFS_FLASH_STATUS && wr_data_i[BIT_BUFFER_EMPTY]))
      else $error("launch without status write");
   read_idle_a: assert property (!rd_i |=> rd_data_o == 8'h00)
      else $error("read data outside read cycle");
   unmapped_read_a: assert property (rd_i && (addr_i < OFFS_FLASH_CONFIG ||
      addr_i > OFFS_FLASH_STATUS) |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   status_zero_a: assert property (status_rd ##0 !special_mode_i |=>
      rd_data_o[3] == 1'b0 && rd_data_o[1:0] == 2'h0)
      else $error("normal mode status bits not zero");
   done_low_a: assert property (status_rd ##0 special_mode_i && op_active_i &&
      $past(op_active_i) |=> !rd_data_o[BIT_DONE])
      else $error("done high while operation active");
   prot_upper_a: assert property (rd_i && addr_i == OFFS_PROTECTION |=>
      rd_data_o[7:3] == 5'h00)
      else $error("protection upper bits not zero");
   scen_cause_a: assert property ($changed(protection_scenario_o) |->
      $past(prot_load_i || (wr_i && addr_i == OFFS_PROTECTION)) ||
      $past(prot_load_i || (wr_i && addr_i == OFFS_PROTECTION), 2))
      else $error("scenario changed without cause");
   scen_three_a: assert property (protection_scenario_o == 3'h3 && !prot_load_i &&
      !$past(prot_load_i) |=> protection_scenario_o == 3'h3)
      else $error("scenario left three");
   launch_irq_a: assert property (cmd_launch_o |-> ##[0:2] !buffer_empty_irq_o)
      else $error("empty request kept after launch");
   cover property (prot_touch);
endmodule : fsp_status_sva

bind fsp_status fsp_status_sva u_sva (
   .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .special_mode_i(special_mode_i),
   .prot_load_i(prot_load_i), .protection_scenario_o(protection_scenario_o),
   .op_active_i(op_active_i), .cmd_launch_o(cmd_launch_o),
   .buffer_empty_irq_o(buffer_empty_irq_o)
);

// ===== sim/fsp_status_tb_top.sv
/* Self-checking bench for the flash status block.
   Assumes the register port and event pulses described for fsp_status. */
`timescale 1ns/1ps
module fsp_status_tb_top;
   import fsp_pkg::*;
   localparam int LOAD = 7, WORDWR = 6, CMDWR = 5, STOP = 4;
   localparam int FREE = 3, VIOL = 2, VPASS = 1, VFAIL = 0;
   // Allowed target scenarios, one mask per source scenario
   localparam logic [7:0] ALLOWED [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                          8'h18, 8'h3c, 8'h5a, 8'hff};
   localparam logic [7:0] CODES [4] = '{CMD_ERASE_VERIFY, CMD_WORD_PROGRAM,
                                        CMD_SECTOR_ERASE, CMD_MASS_ERASE};
   logic              clk_i, reset_i, wr_i, rd_i, special_mode_i;
   logic              engine_busy_i, op_active_i, cmd_launch_o;
   logic              buffer_empty_irq_o, cmd_complete_irq_o;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wr_data_i, rd_data_o;
   logic [SCEN_W-1:0] prot_init_i, protection_scenario_o;
   logic [7:0]        command_code_bits_i, ev;
   int                error_cnt, compares;

   fsp_status dut (
      .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .special_mode_i(special_mode_i),
      .prot_load_i(ev[LOAD]), .prot_init_i(prot_init_i),
      .protection_scenario_o(protection_scenario_o), .array_word_wr_i(ev[WORDWR]),
      .cmd_wr_i(ev[CMDWR]), .command_code_bits_i(command_code_bits_i),
      .stop_i(ev[STOP]), .cmd_launch_o(cmd_launch_o), .buffer_free_i(ev[FREE]),
      .engine_busy_i(engine_busy_i), .op_active_i(op_active_i),
      .prot_viol_i(ev[VIOL]), .verify_pass_i(ev[VPASS]), .verify_fail_i(ev[VFAIL]),
      .buffer_empty_irq_o(buffer_empty_irq_o), .cmd_complete_irq_o(cmd_complete_irq_o)
   );

   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
      compares++;
      if (got !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, e, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk($sformatf("read %h", a), e & m, rd_data_o & m);
   endtask : rd

   task automatic pulse(input int b);
      @(posedge clk_i);
      ev[b] <= 1'b1;
      @(posedge clk_i);
      ev[b] <= 1'b0;
   endtask : pulse

   task automatic launch(input logic [7:0] code, input logic e);
      pulse(WORDWR);
      command_code_bits_i <= code;
      pulse(CMDWR);
      wr(OFFS_FLASH_STATUS, 8'h80);
      #1;
      chk("launch", {7'h0, e}, {7'h0, cmd_launch_o});
   endtask : launch

   task automatic give_verdict;
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial begin
      #40000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      {reset_i, wr_i, rd_i, special_mode_i, engine_busy_i, op_active_i} = 6'h20;
      {addr_i, wr_data_i, prot_init_i, command_code_bits_i, ev} = '0;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc0);
      rd(OFFS_PROTECTION, 8'hff, {5'h0, SCEN_RESET});
      rd(4'h0, 8'hff, 8'h00);
      rd(4'h7, 8'hff, 8'h00);
      wr(OFFS_FLASH_STATUS, 8'h4f);
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc0);
      wr(OFFS_FLASH_CONFIG, 8'hc0);
      rd(OFFS_FLASH_CONFIG, 8'hff, 8'hc0);
      chk("irqs", 8'h03, {6'h0, buffer_empty_irq_o, cmd_complete_irq_o});
      for (int f = 0; f < 8; f++) begin
         for (int t = 0; t < 8; t++) begin
            @(posedge clk_i);
            prot_init_i <= 3'(f);
            pulse(LOAD);
            wr(OFFS_PROTECTION, {5'h0, 3'(t)});
            rd(OFFS_PROTECTION, 8'hff, {5'h0, ALLOWED[f][t] ? 3'(t) : 3'(f)});
            chk("scenario", {5'h0, ALLOWED[f][t] ? 3'(t) : 3'(f)},
                {5'h0, protection_scenario_o});
         end
      end
      @(posedge clk_i);
      engine_busy_i <= 1'b1;
      foreach (CODES[i]) begin
         launch(CODES[i], 1'b1);
         rd(OFFS_FLASH_STATUS, 8'hc0, 8'h00);
         chk("irqs", 8'h00, {6'h0, buffer_empty_irq_o, cmd_complete_irq_o});
         pulse(FREE);
         rd(OFFS_FLASH_STATUS, 8'hc0, 8'h80);
      end
      @(posedge clk_i);
      engine_busy_i <= 1'b0;
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc0);
      pulse(VPASS);
      wr(OFFS_FLASH_STATUS, 8'h04);
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc4);
      launch(CMD_ERASE_VERIFY, 1'b1);
      rd(OFFS_FLASH_STATUS, 8'h04, 8'h00);
      pulse(FREE);
      pulse(WORDWR);
      wr(OFFS_FLASH_STATUS, 8'h00);
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hd0);
      launch(CMD_WORD_PROGRAM, 1'b0);
      pulse(VIOL);
      wr(OFFS_FLASH_STATUS, 8'h00);
      rd(OFFS_FLASH_STATUS, 8'h30, 8'h30);
      launch(CMD_WORD_PROGRAM, 1'b0);
      wr(OFFS_FLASH_STATUS, 8'h30);
      rd(OFFS_FLASH_STATUS, 8'h30, 8'h00);
      pulse(FREE);
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc0);
      launch(8'h21, 1'b0);
      rd(OFFS_FLASH_STATUS, 8'h30, 8'h10);
      wr(OFFS_FLASH_STATUS, 8'h10);
      engine_busy_i <= 1'b1;
      launch(CMD_SECTOR_ERASE, 1'b1);
      pulse(STOP);
      rd(OFFS_FLASH_STATUS, 8'h70, 8'h10);
      wr(OFFS_FLASH_STATUS, 8'h10);
      pulse(FREE);
      engine_busy_i <= 1'b0;
      pulse(STOP);
      pulse(VFAIL);
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc0);
      @(posedge clk_i);
      special_mode_i <= 1'b1;
      op_active_i <= 1'b1;
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc0);
      @(posedge clk_i);
      op_active_i <= 1'b0;
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc1);
      pulse(VFAIL);
      rd(OFFS_FLASH_STATUS, 8'hff, 8'hc3);
      launch(CMD_WORD_PROGRAM, 1'b0);
      wr(OFFS_FLASH_STATUS, 8'h13);
      rd(OFFS_FLASH_STATUS, 8'h3f, 8'h01);
      pulse(FREE);
      launch(CMD_WORD_PROGRAM, 1'b1);
      give_verdict();
   end
endmodule : fsp_status_tb_top
